// file: design/brt_pkg.sv
`default_nettype none
package brt_pkg;
  // ==========================================================
  // Clock and timing
  localparam int  CLK_PERIOD_NS    = 10;
  localparam int  LFOSC_PERIOD_US  = 32;
  localparam int  POWERUP_TIMER_WIDTH       = 11;
  localparam int  POWERUP_TIMER_TICKS       = 2048;
  localparam real POWERUP_TIMER_APPROX_MS   = 65.6;
  localparam real POWERUP_TIMER_NOMINAL_MS  = 66.0;
  localparam real POWERUP_TIMER_PRECISE_MS  = 65.5;
  localparam int  OST_WIDTH        = 10;
  localparam int  OST_TICKS        = 1024;
  localparam int  PLL_LOCK_NS      = 2000000;
  localparam int  PLL_LOCK_CYCLES  = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int  PLL_WIDTH        = 18;

  // ==========================================================
  // Register map
  localparam logic [7:0] RESET_CONTROL_REG_OFS = 8'h00;
  localparam logic [7:0] VREF_CONTROL_ZERO_OFS = 8'h04;
  localparam logic [7:0] SEQ_STATUS_OFS        = 8'h08;
  localparam int         SOFT_EN_BIT           = 6;
  localparam logic       SOFT_EN_RST           = 1'b1;
  localparam int         VREF_STABLE_BIT       = 6;
  localparam int         STAT_STATE_LSB        = 0;
  localparam int         STAT_DET_EN_BIT       = 8;
  localparam int         STAT_BOR_ACTIVE_BIT   = 9;
  localparam int         STAT_RELEASE_BIT      = 10;
  localparam int         STAT_OST_PEND_BIT     = 11;
  localparam logic [1:0] RESP_OKAY             = 2'h0;
  localparam logic [1:0] RESP_SLVERR           = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    BOR_OFF     = 2'h0,
    BOR_SOFT    = 2'h1,
    BOR_NOSLEEP = 2'h2,
    BOR_ON      = 2'h3
  } brt_bor_mode_t;

  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL   = 3'h0,
    OSC_CRYSTAL             = 3'h1,
    OSC_FAST_CRYSTAL        = 3'h2,
    OSC_FAST_CRYSTAL_PLL    = 3'h3,
    OSC_RESISTOR_CAPACITOR  = 3'h4,
    OSC_EXTERNAL_CLOCK      = 3'h5,
    OSC_INTERNAL            = 3'h6
  } brt_osc_mode_t;

  typedef struct packed {
    brt_bor_mode_t brownout_mode_cfg;
    logic          powerup_timer_disable_n;
    brt_osc_mode_t osc_mode;
  } brt_cfg_t;

  typedef enum logic [4:0] {
    ST_HOLD = 5'h01,
    ST_POWERUP_TIMER = 5'h02,
    ST_OST  = 5'h04,
    ST_PLL  = 5'h08,
    ST_RUN  = 5'h10
  } brt_state_t;
endpackage : brt_pkg
`default_nettype wire

// file: design/brt_reset_sequencer.sv
`default_nettype none
module brt_reset_sequencer #(
  parameter int PLL_LOCK_CYCLES = brt_pkg::PLL_LOCK_CYCLES,
  parameter int ADDR_W          = 8
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire brt_pkg::brt_cfg_t cfg,
  input  wire logic              por_pulse,
  input  wire logic              master_clear_n,
  input  wire logic              brownout_trip,
  input  wire logic              vref_ready,
  input  wire logic              low_freq_internal_osc,
  input  wire logic              osc_input_pin,
  input  wire logic              sleep_mode,
  input  wire logic              pm_wake_osc_stopped,
  input  wire logic              other_vref_request,
  output logic                   brownout_detector_en,
  output logic                   fixed_voltage_ref_en,
  output logic                   brownout_active,
  output logic                   reset_release_n,
  output logic                   clock_ready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);
  // ==========================================================
  // Decode helpers
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == ADDR_W'(brt_pkg::RESET_CONTROL_REG_OFS))
           || (a == ADDR_W'(brt_pkg::VREF_CONTROL_ZERO_OFS))
           || (a == ADDR_W'(brt_pkg::SEQ_STATUS_OFS));
  endfunction : reg_hit

  function automatic logic needs_ost(input brt_pkg::brt_osc_mode_t m);
    needs_ost = (m == brt_pkg::OSC_LOW_POWER_CRYSTAL) || (m == brt_pkg::OSC_CRYSTAL)
             || (m == brt_pkg::OSC_FAST_CRYSTAL) || (m == brt_pkg::OSC_FAST_CRYSTAL_PLL);
  endfunction : needs_ost

  // ==========================================================
  // Pin synchronisers
  localparam int NSYNC = 6;
  // Power-on reads as asserted until the pin itself is seen
  localparam logic [NSYNC-1:0] SYNC_RST = 6'h01;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic             lfosc_prev_q;
  logic             osc_prev_q;

  assign pin_raw = {osc_input_pin, low_freq_internal_osc, vref_ready,
                    brownout_trip, master_clear_n, por_pulse};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++)
    begin : g_sync
      always_ff @(posedge mclk)
      begin
        if (!resetn)
        begin
          s1_q[gi] <= SYNC_RST[gi];
          s2_q[gi] <= SYNC_RST[gi];
        end
        else
        begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  logic por_s;
  logic master_clear_n_n_s;
  logic trip_s;
  logic vref_ready_s;
  logic lfosc_tick;
  logic osc_tick;

  assign por_s        = s2_q[0];
  assign master_clear_n_n_s     = s2_q[1];
  assign trip_s       = s2_q[2];
  assign vref_ready_s = s2_q[3];

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      lfosc_prev_q <= 1'b0;
      osc_prev_q   <= 1'b0;
    end
    else
    begin
      lfosc_prev_q <= s2_q[4];
      osc_prev_q   <= s2_q[5];
    end
  end

  assign lfosc_tick = s2_q[4] && !lfosc_prev_q;
  assign osc_tick   = s2_q[5] && !osc_prev_q;

  // ==========================================================
  // Brown-out enable and voltage reference
  logic soft_en_q;
  logic soft_en_vis;
  logic det_en_d;
  logic det_en_q;
  logic vref_en_q;
  logic vref_stable_q;
  logic bor_active_q;
  logic bor_reset;

  assign soft_en_vis = soft_en_q && (cfg.brownout_mode_cfg == brt_pkg::BOR_SOFT);

  always_comb
  begin
    unique case (cfg.brownout_mode_cfg)
      brt_pkg::BOR_OFF:     det_en_d = 1'b0;
      brt_pkg::BOR_SOFT:    det_en_d = soft_en_q;
      brt_pkg::BOR_NOSLEEP: det_en_d = !sleep_mode;
      brt_pkg::BOR_ON:      det_en_d = 1'b1;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      det_en_q  <= 1'b0;
      vref_en_q <= 1'b0;
    end
    else
    begin
      det_en_q  <= det_en_d;
      vref_en_q <= det_en_d || other_vref_request;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      vref_stable_q <= 1'b0;
    else
      vref_stable_q <= vref_en_q && vref_ready_s;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      bor_active_q <= 1'b0;
    else
      bor_active_q <= det_en_d && det_en_q && vref_stable_q;
  end

  assign bor_reset = bor_active_q && trip_s;

  // ==========================================================
  // Time-out sequencer
  brt_pkg::brt_state_t state_q;
  brt_pkg::brt_state_t state_d;
  brt_pkg::brt_state_t after_powerup_timer;
  logic                ost_pend_q;
  logic                wake_q;
  logic                powerup_timer_done;
  logic                ost_done;
  logic                pll_done;
  logic                is_pll;

  assign is_pll     = (cfg.osc_mode == brt_pkg::OSC_FAST_CRYSTAL_PLL);
  assign after_powerup_timer = (ost_pend_q && needs_ost(cfg.osc_mode))
                    ? brt_pkg::ST_OST : brt_pkg::ST_RUN;

  always_comb
  begin
    state_d = state_q;
    if (por_s || bor_reset)
      state_d = brt_pkg::ST_HOLD;
    else
    begin
      unique case (state_q)
        brt_pkg::ST_HOLD:
          if (!cfg.powerup_timer_disable_n)
            state_d = brt_pkg::ST_POWERUP_TIMER;
          else
            state_d = after_powerup_timer;
        brt_pkg::ST_POWERUP_TIMER:
          if (powerup_timer_done)
            state_d = after_powerup_timer;
        brt_pkg::ST_OST:
          if (ost_done)
            state_d = is_pll ? brt_pkg::ST_PLL : brt_pkg::ST_RUN;
        brt_pkg::ST_PLL:
          if (pll_done)
            state_d = brt_pkg::ST_RUN;
        brt_pkg::ST_RUN:
          if (pm_wake_osc_stopped && needs_ost(cfg.osc_mode))
            state_d = brt_pkg::ST_OST;
        default:
          state_d = brt_pkg::ST_HOLD;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      state_q <= brt_pkg::ST_HOLD;
    else
      state_q <= state_d;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      ost_pend_q <= 1'b1;
    else if (por_s)
      ost_pend_q <= 1'b1;
    else if (state_q == brt_pkg::ST_RUN)
      ost_pend_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      wake_q <= 1'b0;
    else if (state_d == brt_pkg::ST_HOLD || state_d == brt_pkg::ST_RUN)
      wake_q <= 1'b0;
    else if (state_q == brt_pkg::ST_RUN && state_d == brt_pkg::ST_OST)
      wake_q <= 1'b1;
  end

  brt_tick_timer #(
    .WIDTH (brt_pkg::POWERUP_TIMER_WIDTH),
    .LIMIT (brt_pkg::POWERUP_TIMER_TICKS)
  ) u_powerup_timer (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (state_q == brt_pkg::ST_POWERUP_TIMER && !bor_reset),
    .tick   (lfosc_tick),
    .done   (powerup_timer_done)
  );

  brt_tick_timer #(
    .WIDTH (brt_pkg::OST_WIDTH),
    .LIMIT (brt_pkg::OST_TICKS)
  ) u_ost (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (state_q == brt_pkg::ST_OST),
    .tick   (osc_tick),
    .done   (ost_done)
  );

  brt_tick_timer #(
    .WIDTH (brt_pkg::PLL_WIDTH),
    .LIMIT (PLL_LOCK_CYCLES)
  ) u_pll (
    .mclk   (mclk),
    .resetn (resetn),
    .run    (state_q == brt_pkg::ST_PLL),
    .tick   (1'b1),
    .done   (pll_done)
  );

  // ==========================================================
  // Reset release outputs
  always_ff @(posedge mclk)
  begin
    if (!resetn)
      reset_release_n <= 1'b0;
    else
      reset_release_n <= (state_q == brt_pkg::ST_RUN || wake_q) && master_clear_n_n_s
                         && !por_s && !bor_reset;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      clock_ready <= 1'b0;
    else
      clock_ready <= (state_q == brt_pkg::ST_RUN);
  end

  assign brownout_detector_en = det_en_q;
  assign fixed_voltage_ref_en = vref_en_q;
  assign brownout_active      = bor_active_q;

  // ==========================================================
  // AXI4-Lite write channel
  logic              aw_have_q;
  logic              w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;

  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
  assign do_write      = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      aw_have_q <= 1'b0;
      awaddr_q  <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end
    else if (do_write)
      aw_have_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      w_have_q <= 1'b0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end
    else if (do_write)
      w_have_q <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= brt_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_hit(awaddr_q) ? brt_pkg::RESP_OKAY : brt_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      soft_en_q <= brt_pkg::SOFT_EN_RST;
    else if (do_write && wstrb_q[0]
             && awaddr_q == ADDR_W'(brt_pkg::RESET_CONTROL_REG_OFS)
             && cfg.brownout_mode_cfg == brt_pkg::BOR_SOFT)
      soft_en_q <= wdata_q[brt_pkg::SOFT_EN_BIT];
  end

  // ==========================================================
  // AXI4-Lite read channel
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == ADDR_W'(brt_pkg::RESET_CONTROL_REG_OFS))
      rd_word[brt_pkg::SOFT_EN_BIT] = soft_en_vis;
    else if (s_axi_araddr == ADDR_W'(brt_pkg::VREF_CONTROL_ZERO_OFS))
      rd_word[brt_pkg::VREF_STABLE_BIT] = vref_stable_q;
    else if (s_axi_araddr == ADDR_W'(brt_pkg::SEQ_STATUS_OFS))
    begin
      rd_word[brt_pkg::STAT_STATE_LSB +: 5]     = state_q;
      rd_word[brt_pkg::STAT_DET_EN_BIT]         = det_en_q;
      rd_word[brt_pkg::STAT_BOR_ACTIVE_BIT]     = bor_active_q;
      rd_word[brt_pkg::STAT_RELEASE_BIT]        = reset_release_n;
      rd_word[brt_pkg::STAT_OST_PEND_BIT]       = ost_pend_q;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= brt_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= reg_hit(s_axi_araddr) ? brt_pkg::RESP_OKAY : brt_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : brt_reset_sequencer
`default_nettype wire

// file: design/brt_tick_timer.sv
`default_nettype none
// ==========================================================
// Stage timer counting ticks while run is high
module brt_tick_timer #(
  parameter int WIDTH = 11,
  parameter int LIMIT = 2048
) (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic tick,
  output logic      done
);
  logic [WIDTH-1:0] cnt_q;
  logic             done_q;

  always_ff @(posedge mclk)
  begin
    if (!resetn || !run)
      cnt_q <= '0;
    else if (tick && !done_q)
      cnt_q <= cnt_q + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn || !run)
      done_q <= 1'b0;
    else if (tick && cnt_q == WIDTH'(LIMIT - 1))
      done_q <= 1'b1;
  end

  assign done = done_q;
endmodule : brt_tick_timer
`default_nettype wire

// file: verification/brownout_and_reset_timers_tb.sv
`default_nettype none
module brownout_and_reset_timers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P   = 6;
  localparam int PLL = 20;
  brt_pkg::brt_cfg_t cfg;
  logic        mclk, resetn, por, master_clear_n_n, trip, vrdy, lfo, oscp, slp, wake, oreq;
  logic        det, vref, act, rel_n, crdy, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat, rd;
  logic [1:0]  bres, rres, rs;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  int          n, t0;

  brt_far_side #(.HALF(P / 2)) osc (.mclk(mclk), .low_freq_internal_osc(lfo),
    .osc_input_pin(oscp));
  brt_reset_sequencer #(.PLL_LOCK_CYCLES(PLL)) dut (
    .mclk(mclk), .resetn(resetn), .cfg(cfg), .por_pulse(por), .master_clear_n(master_clear_n_n),
    .brownout_trip(trip), .vref_ready(vrdy), .low_freq_internal_osc(lfo),
    .osc_input_pin(oscp), .sleep_mode(slp), .pm_wake_osc_stopped(wake),
    .other_vref_request(oreq), .brownout_detector_en(det), .fixed_voltage_ref_en(vref),
    .brownout_active(act), .reset_release_n(rel_n), .clock_ready(crdy),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bres),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rres), .s_axi_rvalid(rv),
    .s_axi_rready(rr));

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cycles++;

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  function automatic bit span_ok(input int v, input int e);
    return v >= e - 12 && v <= e + 30;
  endfunction : span_ok
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
  endtask : cyc
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    br  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    r = bres;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ara <= a;
    arv <= 1'b1;
    rr  <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rres;
  endtask : axi_rd
  task automatic restart(input brt_pkg::brt_cfg_t c);
    resetn <= 1'b0;
    por    <= 1'b1;
    cfg    <= c;
    cyc(12);
    resetn <= 1'b1;
    cyc(4);
    por <= 1'b0;
    t0 = cycles;
  endtask : restart
  task automatic wait_hi(input bit sel, input int lim);
    n = 0;
    while ((sel ? crdy : rel_n) !== 1'b1 && n < lim)
    begin
      @(posedge mclk);
      n++;
    end
  endtask : wait_hi
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (95000) @(posedge mclk);
    fails++;
    tally_and_finish();
  end

  // ==========================================================
  // Tests
  initial
  begin
    {resetn, por, trip, vrdy, slp, wake, oreq, awv, wv, br, arv, rr} = '0;
    {awa, ara, wd} = '0;
    master_clear_n_n = 1'b1;
    cfg = '0;
    @(posedge mclk);
    restart({brt_pkg::BOR_OFF, 1'b1, brt_pkg::OSC_RESISTOR_CAPACITOR});
    wait_hi(0, 40);
    chk(n <= 8, 1);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(4);
    chk(crdy, 1);
    oreq <= 1'b1;
    cyc(2);
    chk(vref, 1);
    chk(det, 0);
    oreq <= 1'b0;
    axi_rd(8'h0C, rd, rs);
    chk(rs, brt_pkg::RESP_SLVERR);
    axi_wr(8'h0C, 32'h40, rs);
    chk(rs, brt_pkg::RESP_SLVERR);
    $display("test rc_no_timeout done");
    for (int m = 0; m < 4; m++)
    begin
      vrdy <= 1'b0;
      restart({m[1:0], 1'b1, brt_pkg::OSC_RESISTOR_CAPACITOR});
      wait_hi(0, 40);
      chk(act, 0);
      trip <= 1'b1;
      cyc(6);
      chk(rel_n, 1);
      trip <= 1'b0;
      vrdy <= 1'b1;
      cyc(6);
      chk(det, m != 0);
      chk(vref, m != 0);
      chk(act, m != 0);
      axi_rd(8'h04, rd, rs);
      chk(rd[6], m != 0);
      axi_rd(8'h00, rd, rs);
      chk(rd[6], m == 1);
      slp <= 1'b1;
      cyc(3);
      chk(det, m[0]);
      slp <= 1'b0;
      cyc(3);
      chk(det, m != 0);
      axi_wr(8'h00, 32'h0, rs);
      cyc(2);
      chk(det, m > 1);
      axi_wr(8'h00, 32'h40, rs);
      axi_rd(8'h00, rd, rs);
      chk(rd[6], m == 1);
      chk(det, m != 0);
      $display("test mode %0d done", m);
    end
    restart({brt_pkg::BOR_SOFT, 1'b0, brt_pkg::OSC_CRYSTAL});
    cyc(100);
    axi_rd(8'h08, rd, rs);
    chk(rd[4:0], 5'h02);
    cyc(2048 * P - 40);
    chk(rel_n, 0);
    axi_rd(8'h08, rd, rs);
    chk(rd[4:0], 5'h04);
    wait_hi(0, 2048 * P);
    chk(span_ok(cycles - t0, (2048 + 1024) * P), 1);
    $display("test crystal_powerup done");
    restart({brt_pkg::BOR_OFF, 1'b1, brt_pkg::OSC_FAST_CRYSTAL_PLL});
    wait_hi(0, 1100 * P);
    chk(span_ok(cycles - t0, 1024 * P + PLL), 1);
    wake <= 1'b1;
    cyc(1);
    wake <= 1'b0;
    cyc(3);
    chk(crdy, 0);
    t0 = cycles;
    wait_hi(1, 1100 * P);
    chk(span_ok(cycles - t0, 1024 * P + PLL), 1);
    chk(rel_n, 1);
    $display("test pll_wake done");
    master_clear_n_n <= 1'b0;
    restart({brt_pkg::BOR_OFF, 1'b0, brt_pkg::OSC_RESISTOR_CAPACITOR});
    cyc(2048 * P + 100);
    chk(rel_n, 0);
    master_clear_n_n <= 1'b1;
    wait_hi(0, 40);
    chk(n <= 5, 1);
    $display("test master_clear done");
    restart({brt_pkg::BOR_ON, 1'b0, brt_pkg::OSC_RESISTOR_CAPACITOR});
    cyc(1000);
    trip <= 1'b1;
    cyc(10);
    trip <= 1'b0;
    t0 = cycles;
    wait_hi(0, 2100 * P);
    chk(span_ok(cycles - t0, 2048 * P), 1);
    $display("test brownout_restart done");
    tally_and_finish();
  end
endmodule : brownout_and_reset_timers_tb
`default_nettype wire

// file: verification/brt_far_side.sv
`default_nettype none
// ==========================================================
// Free-running slow and crystal oscillators
module brt_far_side #(
  parameter int HALF = 3
) (
  input  wire logic mclk,
  output logic      low_freq_internal_osc,
  output logic      osc_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial
  begin
    low_freq_internal_osc = 1'b0;
    osc_input_pin = 1'b0;
  end
  always @(posedge mclk)
  begin
    if (cnt == HALF - 1)
    begin
      cnt <= 0;
      low_freq_internal_osc <= ~low_freq_internal_osc;
      osc_input_pin <= ~osc_input_pin;
    end
    else
      cnt <= cnt + 1;
  end
endmodule : brt_far_side
`default_nettype wire

// file: verification/brt_reset_sequencer_properties.sv
`default_nettype none
// ==========================================================
// Sequencer properties
module brt_reset_sequencer_properties (
  input wire logic              mclk,
  input wire logic              resetn,
  input wire brt_pkg::brt_cfg_t cfg,
  input wire logic              por_pulse,
  input wire logic              master_clear_n,
  input wire logic              brownout_trip,
  input wire logic              vref_ready,
  input wire logic              sleep_mode,
  input wire logic              brownout_detector_en,
  input wire logic              fixed_voltage_ref_en,
  input wire logic              brownout_active,
  input wire logic              reset_release_n,
  input wire logic              clock_ready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  // ==========================================================
  // Detector enable per mode
  property p_mode_off;
    $past(resetn) && $past(cfg.brownout_mode_cfg) == brt_pkg::BOR_OFF |-> !brownout_detector_en;
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("detector on in off mode");
  property p_mode_on;
    $past(resetn) && $past(cfg.brownout_mode_cfg) == brt_pkg::BOR_ON |-> brownout_detector_en;
  endproperty
  a_mode_on: assert property (p_mode_on) else $error("detector off in on mode");
  property p_mode_sleep;
    $past(resetn) && $past(cfg.brownout_mode_cfg) == brt_pkg::BOR_NOSLEEP
      |-> brownout_detector_en == !$past(sleep_mode);
  endproperty
  a_mode_sleep: assert property (p_mode_sleep) else $error("sleep gating wrong");
  property p_ref_with_det;
    brownout_detector_en |-> fixed_voltage_ref_en;
  endproperty
  a_ref_with_det: assert property (p_ref_with_det) else $error("reference not on");
  property p_active_needs_ref;
    (!vref_ready) [*5] |-> !brownout_active;
  endproperty
  a_active_needs_ref: assert property (p_active_needs_ref) else $error("armed early");

  // ==========================================================
  // Reset release and read handshake
  property p_master_clear_n_hold;
    (!master_clear_n) [*6] |-> !reset_release_n;
  endproperty
  a_master_clear_n_hold: assert property (p_master_clear_n_hold) else $error("released under clear");
  property p_por_hold;
    por_pulse [*6] |-> !reset_release_n && !clock_ready;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("released under power-on");
  property p_rel_ready;
    $rose(reset_release_n) |-> clock_ready;
  endproperty
  a_rel_ready: assert property (p_rel_ready) else $error("released before run");
  property p_rc_fast;
    $fell(por_pulse) && cfg.osc_mode == brt_pkg::OSC_RESISTOR_CAPACITOR
      && cfg.powerup_timer_disable_n && master_clear_n && !brownout_trip
      |-> ##[1:12] reset_release_n;
  endproperty
  a_rc_fast: assert property (p_rc_fast) else $error("time-out applied");
  property p_rd_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
endmodule : brt_reset_sequencer_properties

bind brt_reset_sequencer brt_reset_sequencer_properties u_props (
  .mclk(mclk), .resetn(resetn), .cfg(cfg), .por_pulse(por_pulse),
  .master_clear_n(master_clear_n), .brownout_trip(brownout_trip), .vref_ready(vref_ready),
  .sleep_mode(sleep_mode), .brownout_detector_en(brownout_detector_en),
  .fixed_voltage_ref_en(fixed_voltage_ref_en), .brownout_active(brownout_active),
  .reset_release_n(reset_release_n), .clock_ready(clock_ready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
